// >>> verilog/sffe_pkg.sv
/*
  Shared constants and carrier types for the serial flash front end.
  Assumes a 100 MHz core clock and an outside host in clock mode 0 or 3.
*/
package sffe_pkg;

  // ****************************************************************
  // Instruction codes
  // ****************************************************************
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO    = 8'heb;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_READ_4B    = 8'h13;
  localparam logic [7:0] OP_FAST_4B    = 8'h0c;
  localparam logic [7:0] OP_DUAL_4B    = 8'h3c;
  localparam logic [7:0] OP_QUAD_4B    = 8'h6c;
  localparam logic [7:0] OP_ENTER_4B   = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B    = 8'he9;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DO     = 8'h99;
  localparam logic [7:0] OP_WR_STATUS  = 8'h01;

  // ****************************************************************
  // Timing and sizes
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SW_RESET_US     = 30;
  localparam int SW_RESET_CYC    = (SW_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HW_RESET_US     = 1;
  localparam int HW_RESET_CYC    = (HW_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W          = 32;
  localparam int DUMMY_CYC       = 8;
  localparam int SECTOR_SHIFT    = 12;
  localparam logic RESET_ADDR4   = 1'b0;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] oe_n;
  } sffe_pins_s;

  typedef struct packed {
    logic       four_line_enable_bit;
    logic       powerup_addr_mode_bit;
    logic       status_lock_bit;
    logic       protect_complement_bit;
    logic [3:0] block_protect_bits;
  } sffe_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DUMMY = 3'b011,
    ST_DATA  = 3'b100,
    ST_SKIP  = 3'b101
  } sffe_state_e;

endpackage

// >>> verilog/sffe_sync.sv
/*
  Two-flop synchroniser for a bundle of pin levels.
  Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/100ps
module sffe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // ****************************************************************
  // Two stages; the first is read only by the second.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff  <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// >>> verilog/sffe_rst_filter.sv
/*
  Dedicated reset pin qualifier: a low level that lasts the minimum time
  produces a device reset request. Assumes the pin is already synchronised.
*/
`timescale 1ns/100ps
module sffe_rst_filter #(
  parameter int HOLD_CYC = sffe_pkg::HW_RESET_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Pin level and result
  input  wire logic pin_rst_n_sync,
  output logic      hw_reset_ff
);

  logic [15:0] low_cnt_ff;

  // ****************************************************************
  // Count the low time; assert the reset while long enough.
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_cnt_ff  <= 16'h0000;
      hw_reset_ff <= 1'b0;
    end
    else if (pin_rst_n_sync)
    begin
      low_cnt_ff  <= 16'h0000;
      hw_reset_ff <= 1'b0;
    end
    else if (low_cnt_ff < 16'(HOLD_CYC - 1))
    begin
      low_cnt_ff  <= low_cnt_ff + 16'h0001;
    end
    else
    begin
      hw_reset_ff <= 1'b1;
    end
  end

endmodule

// >>> verilog/sffe_top.sv
/*
  Serial flash host-interface front end: chip select, single, two- and
  four-line transfers, pause and write-protect pins, dedicated reset pin,
  3/4-byte address mode. Assumes an SPI host in mode 0 or 3 whose clock
  is far slower than core_clk; all pins are sampled through synchronisers.
*/
// Contract
// RQ1: Chip select high deselects the device and floats every data line.
// RQ2: No instruction accepted until chip select falls after power-up.
// RQ3: Single-line command, address and write bits sampled on rising clock edges.
// RQ4: Single-line read data shifted out, changing on falling clock edges.
// RQ5: Two- and four-line phases: host drives on rising, device drives on falling.
// RQ6: Four-line instructions run only with the four-line enable bit set.
// RQ7: Write-protect pin with lock and protect bits blocks status and sector writes.
// RQ8: Pause low while selected floats outputs and ignores clock and data.
// RQ9: Pause function disabled when the four-line enable bit is set.
// RQ10: Reset pin low for about one microsecond returns to power-on state.
// RQ11: Reset pin acts in every state and idles inactive when open.
// RQ12: Works with clock modes 0 and 3, sampling on rising edges.
// RQ13: Host keeps clock at a fixed level across both chip select edges.
// RQ14: Two-line reads 3Bh and BBh use lines 0 and 1 both ways; the code takes the 3Bh address on line 0 only.
// RQ15: Four-line reads 6Bh and EBh use all four data lines.
// RQ16: Three-byte mode prefixes the extended address register to the address.
// RQ17: Four-byte mode takes the whole address from four bytes.
// RQ18: Power-up address mode comes from the power-up address mode bit.
// RQ19: B7h enters four-byte mode; E9h returns to three-byte mode.
// RQ20: Current address mode is reported as a status bit.
// RQ21: Some basic instructions always take a four-byte address.
// RQ22: 66h then 99h resets; 30 us busy, no commands meanwhile.
// RQ23: Extended address register holds the top address byte.
// RQ24: Reset pin outranks chip select, clock and data lines.
// RQ25: First eight bits after chip select falls are the instruction, MSB first.
`timescale 1ns/100ps
module sffe_top #(
  parameter int SW_RST_CYC = sffe_pkg::SW_RESET_CYC,
  parameter int HW_RST_CYC = sffe_pkg::HW_RESET_CYC
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rstn,
  // Serial bus pins
  input  wire logic                pin_cs_n,
  input  wire logic                pin_sclk,
  input  wire logic                pin_reset_n,
  input  wire logic [3:0]          pin_din,
  output sffe_pkg::sffe_pins_s     pin_out,
  // Configuration bits
  input  wire sffe_pkg::sffe_cfg_s cfg,
  input  wire logic [7:0]          ext_addr_byte,
  // Array side
  input  wire logic [7:0]          rd_data,
  output logic [31:0]              cur_addr_ff,
  output logic                     cmd_valid_ff,
  output logic [7:0]               cmd_code_ff,
  output logic                     wr_status_ok_ff,
  output logic                     sector_ro,
  // Status
  output logic                     current_addr_mode_bit,
  output logic                     busy_ff
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic       cs_n_s;
  logic       sclk_s;
  logic       rst_n_s;
  logic [3:0] din_s;
  logic       hw_reset_ff;

  // Synchroniser starts at the idle levels, so an open reset pin never counts as low.
  sffe_sync #(.W(7), .INIT(7'h5f)) u_sync ( // RQ11
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({pin_cs_n, pin_sclk, pin_reset_n, pin_din}),
    .sync_out ({cs_n_s, sclk_s, rst_n_s, din_s})
  );

  sffe_rst_filter #(.HOLD_CYC(HW_RST_CYC)) u_rstf (
    .core_clk       (core_clk),
    .rstn           (rstn),
    .pin_rst_n_sync (rst_n_s),
    .hw_reset_ff    (hw_reset_ff)
  );

  // ****************************************************************
  // Edge detection on synchronised clock and select.
  // ****************************************************************
  logic sclk_d_ff;
  logic cs_n_d_ff;
  logic armed_ff;
  logic paused;
  logic rise;
  logic fall;
  logic cs_fall;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  // Pause pin is line 3; only a pause while four-line mode is off.
  assign paused  = !cs_n_s && !din_s[3] && !cfg.four_line_enable_bit; // RQ8 RQ9
  assign rise    = sclk_s && !sclk_d_ff && !cs_n_s && !paused; // RQ3 RQ12
  assign fall    = !sclk_s && sclk_d_ff && !cs_n_s && !paused; // RQ4
  assign cs_fall = !cs_n_s && cs_n_d_ff;

  // Only a select fall seen after reset arms the decoder.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      armed_ff <= 1'b0;
    else if (hw_reset_ff)
      armed_ff <= 1'b0; // RQ10 RQ24
    else if (cs_fall)
      armed_ff <= 1'b1; // RQ2
  end

  // ****************************************************************
  // Transfer sequencer
  // ****************************************************************
  sffe_pkg::sffe_state_e state_ff;
  logic [7:0]  shift_ff;
  logic [5:0]  bit_cnt_ff;
  logic [1:0]  width_ff;
  logic        addr4_cmd_ff;
  logic        dummy_ff;
  logic        rst_enable_ff;
  logic [15:0] busy_cnt_ff;
  logic [7:0]  nxt_shift;
  logic [2:0]  lanes;
  logic [31:0] addr_sh_ff;

  // Lines per cycle: width 0 single, 1 two, 2 four.
  assign lanes = (width_ff == 2'd2) ? 3'd4 : (width_ff == 2'd1) ? 3'd2 : 3'd1;

  always_comb
  begin
    nxt_shift = shift_ff;
    unique case (width_ff)
      2'd1:    nxt_shift = {shift_ff[5:0], din_s[1:0]}; // RQ5 RQ14
      2'd2:    nxt_shift = {shift_ff[3:0], din_s[3:0]}; // RQ5 RQ15
      default: nxt_shift = {shift_ff[6:0], din_s[0]};   // RQ3
    endcase
  end

  // Decodes the opcode, collects the address and counts the dummy cycles.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff     <= sffe_pkg::ST_IDLE;
      shift_ff     <= 8'h00;
      bit_cnt_ff   <= 6'd0;
      width_ff     <= 2'd0;
      addr4_cmd_ff <= 1'b0;
      dummy_ff     <= 1'b0;
      cmd_code_ff  <= 8'h00;
      cmd_valid_ff <= 1'b0;
      addr_sh_ff   <= 32'h0;
    end
    else if (hw_reset_ff || cs_n_s || busy_ff)
    begin
      state_ff     <= sffe_pkg::ST_IDLE; // RQ1 RQ22 RQ24
      bit_cnt_ff   <= 6'd0;
      width_ff     <= 2'd0;
      cmd_valid_ff <= 1'b0;
    end
    else
    begin
      cmd_valid_ff <= 1'b0;
      unique case (state_ff)
        sffe_pkg::ST_IDLE:
        begin
          if (armed_ff)
            state_ff <= sffe_pkg::ST_CMD;
          bit_cnt_ff <= 6'd0;
        end
        sffe_pkg::ST_CMD:
        begin
          if (rise)
          begin
            shift_ff   <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 6'd1;
            if (bit_cnt_ff == 6'd7)
            begin
              cmd_code_ff  <= nxt_shift; // RQ25
              cmd_valid_ff <= 1'b1;
              bit_cnt_ff   <= 6'd0;
              dummy_ff     <= 1'b0;
              addr4_cmd_ff <= 1'b0;
              state_ff     <= sffe_pkg::ST_SKIP;
              unique case (nxt_shift)
                sffe_pkg::OP_READ, sffe_pkg::OP_FAST_READ:
                  state_ff <= sffe_pkg::ST_ADDR;
                sffe_pkg::OP_READ_4B, sffe_pkg::OP_FAST_4B:
                begin
                  addr4_cmd_ff <= 1'b1; // RQ21
                  state_ff     <= sffe_pkg::ST_ADDR;
                end
                sffe_pkg::OP_DUAL_OUT, sffe_pkg::OP_DUAL_4B:
                begin
                  addr4_cmd_ff <= (nxt_shift == sffe_pkg::OP_DUAL_4B); // RQ21
                  state_ff     <= sffe_pkg::ST_ADDR;
                end
                sffe_pkg::OP_DUAL_IO:
                begin
                  width_ff <= 2'd1; // RQ14
                  state_ff <= sffe_pkg::ST_ADDR;
                end
                sffe_pkg::OP_QUAD_OUT, sffe_pkg::OP_QUAD_4B, sffe_pkg::OP_QUAD_IO:
                begin
                  if (cfg.four_line_enable_bit) // RQ6 RQ15
                  begin
                    addr4_cmd_ff <= (nxt_shift == sffe_pkg::OP_QUAD_4B);
                    width_ff     <= (nxt_shift == sffe_pkg::OP_QUAD_IO) ? 2'd2 : 2'd0;
                    state_ff     <= sffe_pkg::ST_ADDR;
                  end
                end
                default:
                  state_ff <= sffe_pkg::ST_SKIP;
              endcase
              dummy_ff <= (nxt_shift != sffe_pkg::OP_READ) &&
                          (nxt_shift != sffe_pkg::OP_READ_4B);
            end
          end
        end
        sffe_pkg::ST_ADDR:
        begin
          if (rise)
          begin
            shift_ff   <= nxt_shift;
            addr_sh_ff <= (addr_sh_ff << lanes) | 32'(nxt_shift[3:0] &
                          ((width_ff == 2'd2) ? 4'hf : (width_ff == 2'd1) ? 4'h3 : 4'h1));
            bit_cnt_ff <= bit_cnt_ff + 6'(lanes);
            if (6'(bit_cnt_ff + 6'(lanes)) >=
                ((addr4_cmd_ff || current_addr_mode_bit) ? 6'd32 : 6'd24))
            begin
              bit_cnt_ff <= 6'd0;
              state_ff   <= dummy_ff ? sffe_pkg::ST_DUMMY : sffe_pkg::ST_DATA;
              if (cmd_code_ff == sffe_pkg::OP_DUAL_OUT || cmd_code_ff == sffe_pkg::OP_DUAL_4B)
                width_ff <= 2'd1;
              else if (cmd_code_ff == sffe_pkg::OP_QUAD_OUT ||
                       cmd_code_ff == sffe_pkg::OP_QUAD_4B)
                width_ff <= 2'd2;
            end
          end
        end
        sffe_pkg::ST_DUMMY:
        begin
          if (rise)
          begin
            bit_cnt_ff <= bit_cnt_ff + 6'd1;
            if (bit_cnt_ff == 6'(sffe_pkg::DUMMY_CYC - 1))
            begin
              bit_cnt_ff <= 6'd0;
              state_ff   <= sffe_pkg::ST_DATA;
            end
          end
        end
        sffe_pkg::ST_DATA, sffe_pkg::ST_SKIP:
          state_ff <= state_ff;
        default:
          state_ff <= sffe_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Address mode, address assembly and software reset.
  // ****************************************************************
  logic mode_loaded_ff;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      current_addr_mode_bit <= sffe_pkg::RESET_ADDR4;
      mode_loaded_ff        <= 1'b0;
      rst_enable_ff         <= 1'b0;
    end
    else if (hw_reset_ff)
    begin
      mode_loaded_ff <= 1'b0; // RQ10 RQ11
      rst_enable_ff  <= 1'b0;
    end
    else if (!mode_loaded_ff)
    begin
      current_addr_mode_bit <= cfg.powerup_addr_mode_bit; // RQ18 RQ20
      mode_loaded_ff        <= 1'b1;
    end
    else if (cmd_valid_ff)
    begin
      if (cmd_code_ff == sffe_pkg::OP_ENTER_4B)
        current_addr_mode_bit <= 1'b1; // RQ19
      else if (cmd_code_ff == sffe_pkg::OP_EXIT_4B)
        current_addr_mode_bit <= 1'b0; // RQ19
      else if (cmd_code_ff == sffe_pkg::OP_RST_DO && rst_enable_ff)
        mode_loaded_ff <= 1'b0; // RQ22
      rst_enable_ff <= (cmd_code_ff == sffe_pkg::OP_RST_ENABLE); // RQ22
    end
  end

  // Busy window after a software reset.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_ff     <= 1'b0;
      busy_cnt_ff <= 16'h0000;
    end
    else if (hw_reset_ff)
    begin
      busy_ff     <= 1'b0;
      busy_cnt_ff <= 16'h0000;
    end
    else if (cmd_valid_ff && cmd_code_ff == sffe_pkg::OP_RST_DO && rst_enable_ff)
    begin
      busy_ff     <= 1'b1; // RQ22
      busy_cnt_ff <= 16'(SW_RST_CYC - 1);
    end
    else if (busy_ff)
    begin
      busy_cnt_ff <= busy_cnt_ff - 16'h0001;
      if (busy_cnt_ff == 16'h0000)
        busy_ff <= 1'b0;
    end
  end

  // Final address: extended byte used only in three-byte mode.
  // Follows the shifter past the address phase, so the last address bit is kept.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cur_addr_ff <= 32'h0;
    else if (state_ff inside {sffe_pkg::ST_ADDR, sffe_pkg::ST_DUMMY, sffe_pkg::ST_DATA})
    begin
      if (addr4_cmd_ff || current_addr_mode_bit)
        cur_addr_ff <= addr_sh_ff; // RQ17 RQ21
      else
        cur_addr_ff <= {ext_addr_byte, addr_sh_ff[23:0]}; // RQ16 RQ23
    end
  end

  // ****************************************************************
  // Write protection.
  // ****************************************************************
  localparam int SECTOR_TOP = sffe_pkg::SECTOR_SHIFT + 15;
  logic wp_n;
  logic [15:0] prot_span;

  // Write-protect pin is line 2 unless four-line mode reuses it.
  assign wp_n = cfg.four_line_enable_bit ? 1'b1 : din_s[2];

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      wr_status_ok_ff <= 1'b0;
    else
      wr_status_ok_ff <= !(cfg.status_lock_bit && !wp_n); // RQ7
  end

  // Protected region grows as a power of two of 4KB sectors from the top.
  assign prot_span = (cfg.block_protect_bits == 4'h0) ? 16'h0000 :
                     16'(16'h0001 << cfg.block_protect_bits);
  // Distance from the top is taken one bit wider, so sector zero is not seen as the top.
  assign sector_ro = cfg.protect_complement_bit ^
                     ((17'h10000 - {1'b0, cur_addr_ff[SECTOR_TOP:sffe_pkg::SECTOR_SHIFT]}) <=
                      {1'b0, prot_span} && prot_span != 16'h0000); // RQ7

  // ****************************************************************
  // Output shifter: output data changes on falling clock edges only.
  // ****************************************************************
  logic [7:0] out_sh_ff;
  logic [3:0] dout_ff;
  logic       drive_ff;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_sh_ff <= 8'h00;
      dout_ff   <= 4'h0;
      drive_ff  <= 1'b0;
    end
    else if (cs_n_s || hw_reset_ff || state_ff != sffe_pkg::ST_DATA)
    begin
      drive_ff  <= 1'b0; // RQ1
      out_sh_ff <= rd_data;
    end
    else if (fall)
    begin
      drive_ff <= 1'b1;
      unique case (width_ff)
        2'd1:
        begin
          dout_ff   <= {2'b00, out_sh_ff[7:6]}; // RQ5 RQ14
          out_sh_ff <= (out_sh_ff[5:0] == 6'h00 && out_sh_ff[7:6] != 2'b00) ?
                       {out_sh_ff[5:0], 2'b00} : {out_sh_ff[5:0], 2'b00};
        end
        2'd2:
        begin
          dout_ff   <= out_sh_ff[7:4]; // RQ5 RQ15
          out_sh_ff <= {out_sh_ff[3:0], 4'h0};
        end
        default:
        begin
          dout_ff   <= {2'b00, out_sh_ff[7], 1'b0}; // RQ4
          out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        end
      endcase
    end
  end

  // Enables are active low; pause and deselect float every line.
  always_comb
  begin
    pin_out.dout = dout_ff;
    pin_out.oe_n = 4'hf; // RQ1 RQ8
    if (drive_ff && !cs_n_s && !paused)
    begin
      unique case (width_ff)
        2'd1:    pin_out.oe_n = 4'hc;
        2'd2:    pin_out.oe_n = 4'h0;
        default: pin_out.oe_n = 4'hd;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_float_deselect: assert property (@(posedge core_clk) disable iff (!rstn) // RQ1
    cs_n_s |-> pin_out.oe_n == 4'hf) else $error("Lines driven while deselected.");
  a_pause_float: assert property (@(posedge core_clk) disable iff (!rstn) // RQ8
    paused |-> pin_out.oe_n == 4'hf) else $error("Lines driven while paused.");
  a_quad_gate: assert property (@(posedge core_clk) disable iff (!rstn) // RQ6
    (cmd_valid_ff && cmd_code_ff == sffe_pkg::OP_QUAD_IO && !cfg.four_line_enable_bit)
    |-> width_ff != 2'd2) else $error("Four-line run without enable.");
  a_no_arm_cmd: assert property (@(posedge core_clk) disable iff (!rstn) // RQ2
    !armed_ff |=> !cmd_valid_ff) else $error("Instruction before select fall.");
  a_enter_4b: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
    (cmd_valid_ff && cmd_code_ff == sffe_pkg::OP_ENTER_4B && mode_loaded_ff && !hw_reset_ff)
    |=> current_addr_mode_bit) else $error("Enter four-byte ignored.");
  a_exit_4b: assert property (@(posedge core_clk) disable iff (!rstn) // RQ19
    (cmd_valid_ff && cmd_code_ff == sffe_pkg::OP_EXIT_4B && mode_loaded_ff && !hw_reset_ff)
    |=> !current_addr_mode_bit) else $error("Exit four-byte ignored.");
  a_sw_busy: assert property (@(posedge core_clk) disable iff (!rstn) // RQ22
    (cmd_valid_ff && cmd_code_ff == sffe_pkg::OP_RST_DO && rst_enable_ff && !hw_reset_ff)
    |=> busy_ff [*8]) else $error("Reset busy window too short.");
  a_hw_reset: assert property (@(posedge core_clk) disable iff (!rstn) // RQ10
    hw_reset_ff |=> state_ff == sffe_pkg::ST_IDLE && !armed_ff) else $error("Reset pin ignored.");
  a_out_fall: assert property (@(posedge core_clk) disable iff (!rstn) // RQ4
    $changed(dout_ff) |-> $past(fall)) else $error("Output changed off a falling edge.");
  c_quad_read: cover property (@(posedge core_clk) state_ff == sffe_pkg::ST_DATA && width_ff == 2'd2);
  c_dual_read: cover property (@(posedge core_clk) state_ff == sffe_pkg::ST_DATA && width_ff == 2'd1);
  c_sw_reset: cover property (@(posedge core_clk) $rose(busy_ff));
  c_pause: cover property (@(posedge core_clk) $rose(paused));

endmodule

// >>> verification/sffe_host_model.sv
/*
  Behavioural SPI host for the flash front end.
  Assumes a 100 MHz core_clk; the link half period is four core cycles.
*/
`timescale 1ns/100ps
module sffe_host_model (
  // Clock and device side
  input  wire logic       core_clk,
  input  wire logic [3:0] dev_dout,
  input  wire logic [3:0] dev_oe_n,
  input  wire logic       wp_n,
  input  wire logic       pause_n,
  // Host pins
  output logic            pin_cs_n,
  output logic            pin_sclk,
  output logic [3:0]      pin_din
);
  logic d0      = 1'b0;
  logic m3      = 1'b0;
  logic last_ff = 1'b0;

  // A released line 1 toggles, so a float never reads as stale data.
  assign pin_din = {pause_n, wp_n, dev_oe_n[1] ? ~last_ff : dev_dout[1], d0};

  // Track the last level of line 1.
  always @(posedge core_clk) last_ff <= pin_din[1];

  // Idle bus at time zero.
  initial
  begin
    pin_cs_n = 1'b1;
    pin_sclk = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask

  // Opens a frame with the clock parked at the mode's idle level.
  task automatic open(input logic mode3);
    m3 = mode3;
    pin_sclk <= mode3;
    half();
    pin_cs_n <= 1'b0;
    half();
  endtask

  // Sends n bits MSB first on line 0, sampling line 1 before each rise.
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--)
    begin
      pin_sclk <= 1'b0;
      d0 <= v[i];
      half();
      rx = {rx[30:0], pin_din[1]};
      pin_sclk <= 1'b1;
      half();
    end
  endtask

  // Closes the frame with the clock back at its idle level.
  task automatic close();
    pin_sclk <= m3;
    half();
    pin_cs_n <= 1'b1;
    half();
  endtask
endmodule

// >>> verification/test_sffe_top.sv
/*
  Self-checking bench for the flash front end.
  Assumes the host model drives the serial pins.
*/
`timescale 1ns/100ps
module test_sffe_top;
  logic                 core_clk    = 1'b0;
  logic                 rstn        = 1'b0;
  logic                 pin_reset_n = 1'b1;
  logic                 pause_n     = 1'b1;
  logic                 cs_n;
  logic                 sclk;
  logic [3:0]           din;
  sffe_pkg::sffe_pins_s pin_out;
  sffe_pkg::sffe_cfg_s  cfg         = '0;
  logic [7:0]           ext_addr    = 8'h00;
  logic [7:0]           rd_data     = 8'h00;
  logic [31:0]          cur_addr;
  logic [31:0]          rx;
  logic [31:0]          a;
  logic [31:0]          seed        = 32'd18;
  logic [7:0]           code;
  logic                 vld;
  logic                 mode_bit;
  logic                 busy;
  logic                 wp_n        = 1'b1;
  logic                 ws_ok;
  logic                 ro;
  logic [7:0]           op;
  int                   vld_cnt     = 0;
  int                   error_cnt   = 0;
  int                   checks      = 0;

  sffe_top #(.SW_RST_CYC(200), .HW_RST_CYC(4)) sffe_top_i (
    .core_clk(core_clk), .rstn(rstn), .pin_cs_n(cs_n), .pin_sclk(sclk),
    .pin_reset_n(pin_reset_n), .pin_din(din), .pin_out(pin_out), .cfg(cfg),
    .ext_addr_byte(ext_addr), .rd_data(rd_data), .cur_addr_ff(cur_addr),
    .cmd_valid_ff(vld), .cmd_code_ff(code), .wr_status_ok_ff(ws_ok), .sector_ro(ro),
    .current_addr_mode_bit(mode_bit), .busy_ff(busy));

  sffe_host_model sffe_host_model_i (
    .core_clk(core_clk), .dev_dout(pin_out.dout), .dev_oe_n(pin_out.oe_n),
    .wp_n(wp_n), .pause_n(pause_n), .pin_cs_n(cs_n), .pin_sclk(sclk), .pin_din(din));

  // Counts instruction pulses.
  always @(posedge core_clk) if (vld === 1'b1) vld_cnt++;

  // Core clock.
  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One frame in a random clock mode: opcode, address bits, data bits.
  task automatic frame(input logic [7:0] c, input int na, input int nd);
    void'(rnd());
    sffe_host_model_i.open(seed[0]);
    sffe_host_model_i.shift(32'(c), 8, rx);
    if (na > 0) sffe_host_model_i.shift(a, na, rx);
    if (nd > 0) sffe_host_model_i.shift(32'h0, nd, rx);
    sffe_host_model_i.close();
    repeat (4) @(posedge core_clk);
  endtask

  // Main sequence.
  initial
  begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(pin_out.oe_n), 32'hf);
    chk(32'(mode_bit), 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      op = {2'b00, 6'(rnd())};
      code_loop: frame(op, 0, 0);
      chk(32'(code), 32'(op));
    end
    chk(32'(vld_cnt), 32'd6);
    $display("test opcodes done");
    a = rnd();
    ext_addr <= 8'(rnd());
    rd_data <= 8'(rnd());
    frame(sffe_pkg::OP_READ, 24, 8);
    chk(cur_addr, {ext_addr, a[23:0]});
    chk(32'(rx[7:0]), 32'(rd_data));
    chk(32'(pin_out.oe_n), 32'hf);
    frame(sffe_pkg::OP_READ_4B, 32, 0);
    chk(cur_addr, a);
    frame(sffe_pkg::OP_ENTER_4B, 0, 0);
    chk(32'(mode_bit), 32'h1);
    a = rnd();
    frame(sffe_pkg::OP_READ, 32, 0);
    chk(cur_addr, a);
    cfg.block_protect_bits <= 4'hf;
    cfg.status_lock_bit    <= 1'b1;
    wp_n                   <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(32'(ro), 32'(a[27]));
    chk(32'(ws_ok), 32'h0);
    cfg.protect_complement_bit <= 1'b1;
    wp_n                       <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(ro), 32'(!a[27]));
    chk(32'(ws_ok), 32'h1);
    frame(sffe_pkg::OP_EXIT_4B, 0, 0);
    chk(32'(mode_bit), 32'h0);
    frame(sffe_pkg::OP_QUAD_IO, 24, 0);
    chk(cur_addr, a);
    $display("test addressing done");
    fork
      frame(sffe_pkg::OP_READ, 24, 8);
      begin
        wait (pin_out.oe_n[1] === 1'b0);
        pause_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(32'(pin_out.oe_n[1]), 32'h1);
        pause_n <= 1'b1;
      end
    join
    frame(sffe_pkg::OP_RST_ENABLE, 0, 0);
    frame(sffe_pkg::OP_RST_DO, 0, 0);
    chk(32'(busy), 32'h1);
    frame(sffe_pkg::OP_ENTER_4B, 0, 0);
    chk(32'(mode_bit), 32'h0);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge core_clk);
    chk(32'(busy), 32'h0);
    frame(sffe_pkg::OP_ENTER_4B, 0, 0);
    chk(32'(mode_bit), 32'h1);
    sffe_host_model_i.open(1'b0);
    pin_reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    pin_reset_n <= 1'b1;
    sffe_host_model_i.close();
    chk(32'(mode_bit), 32'h0);
    $display("test resets done");
    conclude();
  end

  // Watchdog well past the expected run length.
  initial
  begin
    #200us;
    error_cnt++;
    conclude();
  end
endmodule
